// File: hw/data_link_if.sv
// Purpose: lanes between the data source and the parity and alarm monitor
// Assumes: the source makes the data clock; data changes away from both edges
// Notes:   all lanes are one-way, source to device
`timescale 1ns/1ps
`default_nettype none
interface data_link_if;
   logic                                dataclk;
   logic [parity_alarm_pkg::DATA_W-1:0] data;
   logic                                check_bit_lane;
   logic                                frame_lane;

   modport device (
      input dataclk,
      input data,
      input check_bit_lane,
      input frame_lane
   );
   modport source (
      output dataclk,
      output data,
      output check_bit_lane,
      output frame_lane
   );
endinterface
`default_nettype wire

// File: hw/data_source_end.sv
// Purpose: data source end; divides mclk into the data clock and sends words
// Assumes: user supplies a word on each ready slot; idle slots send zero words
// Notes:   a block start is honoured only on the rising-edge slot
`timescale 1ns/1ps
`default_nettype none
module data_source_end (
   // clock and reset
   input  wire logic                                mclk,
   input  wire logic                                resetn,
   // link to the device
   data_link_if.source                              link,
   // user word stream
   input  wire logic [parity_alarm_pkg::DATA_W-1:0] word_data,
   input  wire logic                                word_valid,
   input  wire logic                                block_start,
   output logic                                     word_ready,
   // settings
   input  wire logic                                word_par_ena,
   input  wire logic                                odd_sense,
   input  wire logic                                block_par_ena,
   input  wire logic                                corrupt
);
   import parity_alarm_pkg::*;

   logic [1:0]        phase_reg;
   logic              acc_reg;
   logic              closed_reg;
   logic              pend_reg;
   logic              take;
   logic [DATA_W-1:0] word;

   assign take = word_ready & word_valid;
   assign word = take ? word_data : '0;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         phase_reg    <= PH_RISE;
         link.dataclk <= 1'b0;
         word_ready   <= 1'b0;
      end else begin
         phase_reg    <= phase_reg + 2'h1;
         word_ready   <= (phase_reg == PH_RISE) || (phase_reg == PH_FALL);
         if (phase_reg == PH_RISE) begin
            link.dataclk <= 1'b1;
         end else if (phase_reg == PH_FALL) begin
            link.dataclk <= 1'b0;
         end
      end
   end

   // [R1] word plus check bit on each slot
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         link.data           <= '0;
         link.check_bit_lane <= 1'b0;
      end else if ((phase_reg == PH_LOADF) || (phase_reg == PH_LOADR)) begin
         link.data           <= word;
         link.check_bit_lane <= word_par_ena & (word_ones_odd(word) ^ odd_sense ^ corrupt);
      end
   end

   // [R7] [R9] [R10] frame marks and block parity
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         link.frame_lane <= 1'b0;
         acc_reg         <= 1'b0;
         closed_reg      <= 1'b0;
         pend_reg        <= 1'b0;
      end else if (phase_reg == PH_LOADR) begin
         if (take && block_start) begin
            link.frame_lane <= 1'b1;
            closed_reg      <= acc_reg;
            acc_reg         <= word_ones_odd(word);
            pend_reg        <= 1'b1;
         end else begin
            link.frame_lane <= 1'b0;
            acc_reg         <= acc_reg ^ word_ones_odd(word);
         end
      end else if (phase_reg == PH_LOADF) begin
         link.frame_lane <= pend_reg & block_par_ena & (closed_reg ^ corrupt);
         pend_reg        <= 1'b0;
         acc_reg         <= acc_reg ^ word_ones_odd(word);
      end
   end
endmodule
`default_nettype wire

// File: hw/parity_alarm_monitor.sv
// Purpose: word and block parity checking plus sticky alarm collection and masking
// Assumes: fifo pointers, pll lock, pattern result and tx pin come in asynchronously
// Notes:   register port on mclk; parity checking on both data clock edges
// Function
// [R1] word mode checks each word with check bit
// [R2] count ones over seventeen lanes
// [R3] sense bit one selects odd parity
// [R4] rising and falling words flagged separately
// [R5] block mode uses frame lane boundaries
// [R6] frame rise on rising edge closes block
// [R7] expected parity from next falling frame sample
// [R8] mismatch sets the block parity alarm
// [R9] blocks multiple of eight samples
// [R10] block boundaries align with data frames
// [R11] alarms readable, on pin, sticky
// [R12] all-zero write pointer raises zero check
// [R13] pointer distance alarms and general fifo alarm
// [R14] separate clock stop alarms plus combined
// [R15] pll unlock and pattern mismatch alarms
// [R16] only unmasked alarms reach the pin
// [R17] configured alarms force outputs off
// [R18] software clears and rereads until clean
// [R19] write zero clears, persisting cause resets
// [R20] timeout counters, sets synchronised before storing
`timescale 1ns/1ps
`default_nettype none
module parity_alarm_monitor (
   // clock and reset
   input  wire logic                                    mclk,
   input  wire logic                                    resetn,
   // link from the source
   data_link_if.device                                  link,
   // register port
   input  wire logic                                    reg_wr,
   input  wire logic [parity_alarm_pkg::REG_ADDR_W-1:0] reg_addr,
   input  wire logic [parity_alarm_pkg::DATA_W-1:0]     reg_wdata,
   output logic      [parity_alarm_pkg::DATA_W-1:0]     reg_rdata,
   // device status inputs
   input  wire logic [parity_alarm_pkg::PTR_W-1:0]      fifo_wr_ptr,
   input  wire logic [parity_alarm_pkg::PTR_W-1:0]      fifo_rd_ptr,
   input  wire logic                                    pll_locked,
   input  wire logic                                    pattern_mismatch,
   input  wire logic                                    tx_enable_pin,
   // outputs
   output logic                                         alarm_pin,
   output logic                                         dac_out_on
);
   import parity_alarm_pkg::*;

   localparam int SYNC_W = 5;
   localparam int ST_W   = 2 * PTR_W + 3;

   // ---------------- link domain, plus the mclk-side link reset and beat counters ----------------
   localparam int LRST_W = 5;
   localparam int BEAT_W = 4;
   logic [LRST_W-1:0]  lrst_cnt_reg;
   logic               lrst_req_reg;
   logic [BEAT_W-1:0]  beat_cnt_reg;
   logic               lrst_meta;
   logic               lrst_n;
   logic [SETUP_W-1:0] cfg_meta;
   logic [SETUP_W-1:0] cfg_sync;
   logic               frame_prev_reg;
   logic               acc_r_reg;
   logic               closed_r_reg;
   logic               primed_reg;
   logic               chk_tgl_reg;
   logic               r_err_tgl_reg;
   logic               f_err_tgl_reg;
   logic               acc_f_reg;
   logic               chk_seen_reg;
   logic               link_beat_reg;
   logic               mbeat_meta;
   logic               mbeat_s2;
   logic               mbeat_s3;
   logic [CNT_W-1:0]   dac_cnt_reg;
   logic               dacclk_gone_reg;
   logic               frame_rise;

   // ---------------- mclk domain ----------------
   logic [DATA_W-1:0]  setup_reg;
   logic [DATA_W-1:0]  shutoff_reg;
   logic [DATA_W-1:0]  status_reg;
   logic [DATA_W-1:0]  mask_reg;
   logic [DATA_W-1:0]  alarm_set;
   logic [SYNC_W-1:0]  tg_meta;
   logic [SYNC_W-1:0]  tg_s2;
   logic [SYNC_W-1:0]  tg_s3;
   logic [ST_W-1:0]    st_meta;
   logic [ST_W-1:0]    st_sync;
   logic               mbeat_reg;
   logic [CNT_W-1:0]   data_cnt_reg;
   logic               dataclk_gone;
   logic [IDX_W-1:0]   ptr_gap;
   logic               force_off;

   // link reset outlasts mclk reset so it is seen once the data clock runs
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         lrst_cnt_reg <= '0;
         lrst_req_reg <= 1'b0;
      end else if (lrst_cnt_reg != '1) begin
         lrst_cnt_reg <= lrst_cnt_reg + LRST_W'(1);
      end else begin
         lrst_req_reg <= 1'b1;
      end
   end

   always_ff @(posedge link.dataclk) begin
      lrst_meta <= lrst_req_reg;
      lrst_n    <= lrst_meta;
   end

   always_ff @(posedge link.dataclk) begin
      cfg_meta <= setup_reg[SETUP_W-1:0];
      cfg_sync <= cfg_meta;
   end

   // [R1] [R2] [R3] [R4] rising word check
   always_ff @(posedge link.dataclk) begin
      if (!lrst_n) begin
         r_err_tgl_reg <= 1'b0;
      end else if (cfg_sync[SETUP_WORD_PAR] &&
                   ((word_ones_odd(link.data) ^ link.check_bit_lane) != cfg_sync[SETUP_ODD])) begin
         r_err_tgl_reg <= ~r_err_tgl_reg;
      end
   end

   // [R1] [R2] [R3] [R4] falling word check
   always_ff @(negedge link.dataclk) begin
      if (!lrst_n) begin
         f_err_tgl_reg <= 1'b0;
      end else if (cfg_sync[SETUP_WORD_PAR] &&
                   ((word_ones_odd(link.data) ^ link.check_bit_lane) != cfg_sync[SETUP_ODD])) begin
         f_err_tgl_reg <= ~f_err_tgl_reg;
      end
   end

   assign frame_rise = link.frame_lane & ~frame_prev_reg;

   // [R5] [R6] block boundary on rising edge
   always_ff @(posedge link.dataclk) begin
      if (!lrst_n) begin
         frame_prev_reg <= 1'b1;
         acc_r_reg      <= 1'b0;
         closed_r_reg   <= 1'b0;
         primed_reg     <= 1'b0;
         chk_tgl_reg    <= 1'b0;
      end else begin
         frame_prev_reg <= link.frame_lane;
         if (!cfg_sync[SETUP_FRAME_PAR]) begin
            primed_reg <= 1'b0;
         end else if (frame_rise) begin
            closed_r_reg <= acc_r_reg;
            acc_r_reg    <= word_ones_odd(link.data);
            primed_reg   <= 1'b1;
            if (primed_reg) begin
               chk_tgl_reg <= ~chk_tgl_reg;
            end
         end else begin
            acc_r_reg <= acc_r_reg ^ word_ones_odd(link.data);
         end
      end
   end

   // [R7] [R8] compare on falling edge after boundary
   always_ff @(negedge link.dataclk) begin
      if (!lrst_n) begin
         acc_f_reg    <= 1'b0;
         chk_seen_reg <= 1'b0;
      end else if (chk_tgl_reg != chk_seen_reg) begin
         chk_seen_reg <= chk_tgl_reg;
         acc_f_reg    <= word_ones_odd(link.data);
      end else begin
         acc_f_reg <= acc_f_reg ^ word_ones_odd(link.data);
      end
   end

   logic blk_err_tgl_reg;
   // [R8] block mismatch event
   always_ff @(negedge link.dataclk) begin
      if (!lrst_n) begin
         blk_err_tgl_reg <= 1'b0;
      end else if ((chk_tgl_reg != chk_seen_reg) &&
                   ((closed_r_reg ^ acc_f_reg) != link.frame_lane)) begin
         blk_err_tgl_reg <= ~blk_err_tgl_reg;
      end
   end

   // [R14] [R20] sample clock watchdog in link domain
   always_ff @(posedge link.dataclk) begin
      mbeat_meta <= mbeat_reg;
      mbeat_s2   <= mbeat_meta;
      mbeat_s3   <= mbeat_s2;
   end

   always_ff @(posedge link.dataclk) begin
      if (!lrst_n) begin
         link_beat_reg   <= 1'b0;
         dac_cnt_reg     <= '0;
         dacclk_gone_reg <= 1'b0;
      end else begin
         link_beat_reg <= ~link_beat_reg;
         if (mbeat_s2 != mbeat_s3) begin
            dac_cnt_reg     <= '0;
            dacclk_gone_reg <= 1'b0;
         end else if (dac_cnt_reg >= DACCLK_GONE_EDGES) begin
            dacclk_gone_reg <= 1'b1;
         end else begin
            dac_cnt_reg <= dac_cnt_reg + CNT_W'(1);
         end
      end
   end

   // [R20] link events into mclk
   always_ff @(posedge mclk) begin
      tg_meta <= {dacclk_gone_reg, link_beat_reg, blk_err_tgl_reg, f_err_tgl_reg, r_err_tgl_reg};
      tg_s2   <= tg_meta;
      tg_s3   <= tg_s2;
      st_meta <= {tx_enable_pin, pattern_mismatch, pll_locked, fifo_rd_ptr, fifo_wr_ptr};
      st_sync <= st_meta;
   end

   // [R14] [R20] data clock watchdog in mclk domain
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         beat_cnt_reg <= '0;
         mbeat_reg    <= 1'b0;
         data_cnt_reg <= '0;
      end else begin
         // slow beat so link-edge samples are not aliased to one phase
         beat_cnt_reg <= beat_cnt_reg + BEAT_W'(1);
         mbeat_reg    <= beat_cnt_reg[BEAT_W-1];
         if (tg_s2[3] != tg_s3[3]) begin
            data_cnt_reg <= '0;
         end else if (data_cnt_reg < DATACLK_GONE_CYC) begin
            data_cnt_reg <= data_cnt_reg + CNT_W'(1);
         end
      end
   end

   assign dataclk_gone = (data_cnt_reg >= DATACLK_GONE_CYC);
   assign ptr_gap = onehot_index(st_sync[PTR_W-1:0]) - onehot_index(st_sync[2*PTR_W-1:PTR_W]);

   always_comb begin
      alarm_set = '0;
      // [R12] zero check
      alarm_set[AL_ZERO_CHK]  = (st_sync[PTR_W-1:0] == '0);
      // [R13] pointer distance
      alarm_set[AL_COLLISION] = (ptr_gap == IDX_W'(0));
      alarm_set[AL_ONE_APART] = (ptr_gap == IDX_W'(1)) || (ptr_gap == IDX_W'(PTR_W - 1));
      alarm_set[AL_TWO_APART] = (ptr_gap == IDX_W'(2)) || (ptr_gap == IDX_W'(PTR_W - 2));
      alarm_set[AL_FIFO]      = alarm_set[AL_COLLISION] | alarm_set[AL_ONE_APART] |
                                alarm_set[AL_TWO_APART];
      // [R14] clock alarms
      alarm_set[AL_DACCLK]     = tg_s2[4];
      alarm_set[AL_DATACLK]    = dataclk_gone;
      alarm_set[AL_CLOCK_GONE] = tg_s2[4] | dataclk_gone;
      // [R15] pll and pattern
      alarm_set[AL_PLL]    = ~st_sync[2*PTR_W];
      alarm_set[AL_IOTEST] = st_sync[2*PTR_W+1];
      // [R4] [R8] parity events
      alarm_set[AL_RPARITY]   = tg_s2[0] ^ tg_s3[0];
      alarm_set[AL_FPARITY]   = tg_s2[1] ^ tg_s3[1];
      alarm_set[AL_FRAME_PAR] = tg_s2[2] ^ tg_s3[2];
   end

   // [R11] [R19] sticky status, write zero clears, set wins
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         status_reg <= STATUS_RESET;
      end else if (reg_wr && (reg_addr == ADDR_STATUS)) begin
         status_reg <= (status_reg & reg_wdata) | alarm_set;
      end else begin
         status_reg <= status_reg | alarm_set;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         setup_reg   <= SETUP_RESET;
         shutoff_reg <= SHUTOFF_RESET;
         mask_reg    <= MASK_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_SETUP:   setup_reg   <= reg_wdata;
            ADDR_SHUTOFF: shutoff_reg <= reg_wdata;
            ADDR_MASK:    mask_reg    <= reg_wdata;
            default:      setup_reg   <= setup_reg;
         endcase
      end
   end

   // [R11] read back
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else begin
         case (reg_addr)
            ADDR_SETUP:   reg_rdata <= setup_reg;
            ADDR_SHUTOFF: reg_rdata <= shutoff_reg;
            ADDR_STATUS:  reg_rdata <= status_reg;
            ADDR_MASK:    reg_rdata <= mask_reg;
            default:      reg_rdata <= '0;
         endcase
      end
   end

   // [R17] automatic output shutoff
   assign force_off = (shutoff_reg[SHUT_CLOCK] & status_reg[AL_CLOCK_GONE]) |
                      (shutoff_reg[SHUT_COLLIDE] & status_reg[AL_COLLISION]);

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         alarm_pin  <= 1'b0;
         dac_out_on <= 1'b0;
      end else begin
         // [R16] masked alarm pin
         alarm_pin  <= |(status_reg & ~mask_reg);
         // [R17] override of both enables
         dac_out_on <= st_sync[2*PTR_W+2] & shutoff_reg[SHUT_SIF_TX] & ~force_off;
      end
   end
endmodule
`default_nettype wire

// File: hw/parity_alarm_pkg.sv
// Purpose: shared constants, register map and helpers for the parity and alarm link
// Assumes: one-hot write/read fifo pointers of eight entries
// Notes:   register offsets index a small word-wide register port
package parity_alarm_pkg;
   localparam int DATA_W     = 16;
   localparam int PTR_W      = 8;
   localparam int IDX_W      = 3;
   localparam int REG_ADDR_W = 3;
   localparam int CNT_W      = 8;

   // register offsets
   localparam logic [REG_ADDR_W-1:0] ADDR_SETUP   = 3'h1;
   localparam logic [REG_ADDR_W-1:0] ADDR_SHUTOFF = 3'h2;
   localparam logic [REG_ADDR_W-1:0] ADDR_STATUS  = 3'h5;
   localparam logic [REG_ADDR_W-1:0] ADDR_MASK    = 3'h7;

   // interface_setup_register fields
   localparam int SETUP_WORD_PAR  = 0;
   localparam int SETUP_ODD       = 1;
   localparam int SETUP_FRAME_PAR = 2;
   localparam int SETUP_W         = 3;
   // shutoff_setup_register fields
   localparam int SHUT_CLOCK   = 0;
   localparam int SHUT_COLLIDE = 1;
   localparam int SHUT_SIF_TX  = 2;

   // alarm_status_register bit positions
   localparam int AL_ZERO_CHK   = 0;
   localparam int AL_FIFO       = 1;
   localparam int AL_TWO_APART  = 2;
   localparam int AL_ONE_APART  = 3;
   localparam int AL_COLLISION  = 4;
   localparam int AL_CLOCK_GONE = 5;
   localparam int AL_DACCLK     = 6;
   localparam int AL_IOTEST     = 7;
   localparam int AL_DATACLK    = 8;
   localparam int AL_PLL        = 9;
   localparam int AL_RPARITY    = 10;
   localparam int AL_FPARITY    = 11;
   localparam int AL_FRAME_PAR  = 12;

   localparam logic [DATA_W-1:0] SETUP_RESET   = 16'h0000;
   localparam logic [DATA_W-1:0] SHUTOFF_RESET = 16'h0004;
   localparam logic [DATA_W-1:0] STATUS_RESET  = 16'h0000;
   localparam logic [DATA_W-1:0] MASK_RESET    = 16'hFFFF;

   // timing
   localparam int MCLK_PERIOD_NS = 20;
   localparam int LINK_DIV       = 4;
   localparam int LINK_PERIOD_NS = MCLK_PERIOD_NS * LINK_DIV;
   localparam int CLK_GONE_NS    = 2000;
   localparam logic [CNT_W-1:0] DATACLK_GONE_CYC =
      CNT_W'((CLK_GONE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] DACCLK_GONE_EDGES =
      CNT_W'((CLK_GONE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
   localparam logic [1:0] PH_RISE  = 2'h0;
   localparam logic [1:0] PH_LOADF = 2'h1;
   localparam logic [1:0] PH_FALL  = 2'h2;
   localparam logic [1:0] PH_LOADR = 2'h3;

   function automatic logic word_ones_odd(input logic [DATA_W-1:0] w);
      return ^w;
   endfunction

   function automatic logic [IDX_W-1:0] onehot_index(input logic [PTR_W-1:0] p);
      logic [IDX_W-1:0] idx;
      idx = '0;
      for (int i = 0; i < PTR_W; i++) begin
         if (p[i]) begin
            idx = IDX_W'(i);
         end
      end
      return idx;
   endfunction
endpackage

// File: tb/input_parity_and_alarm_monitor_tb.sv
// Purpose: source end and monitor joined on one link, driven through registers
// Assumes: both ends share mclk and resetn
// Notes:   expected values come from the package constants and from literals in the tasks
`timescale 1ns/1ps
`default_nettype none
module input_parity_and_alarm_monitor_tb;
   import parity_alarm_pkg::*;
   logic                  mclk, resetn, reg_wr, word_valid, block_start, word_ready;
   logic                  word_par_ena, odd_sense, block_par_ena, corrupt;
   logic                  pll_locked, pattern_mismatch, tx_enable_pin, alarm_pin, dac_out_on;
   logic [REG_ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0]     reg_wdata, reg_rdata, word_data, rd_val;
   logic [PTR_W-1:0]      fifo_wr_ptr, fifo_rd_ptr;
   int                    n_errors, cmp_count, word_cnt;

   data_link_if data_link_if_i ();
   parity_alarm_monitor parity_alarm_monitor_i (.mclk, .resetn, .link(data_link_if_i),
      .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .fifo_wr_ptr, .fifo_rd_ptr, .pll_locked,
      .pattern_mismatch, .tx_enable_pin, .alarm_pin, .dac_out_on);
   data_source_end data_source_end_i (.mclk, .resetn, .link(data_link_if_i), .word_data,
      .word_valid, .block_start, .word_ready, .word_par_ena, .odd_sense, .block_par_ena,
      .corrupt);
   parity_link_assertions parity_link_assertions_i (.mclk, .resetn,
      .dataclk(data_link_if_i.dataclk), .data(data_link_if_i.data),
      .check_bit_lane(data_link_if_i.check_bit_lane), .frame_lane(data_link_if_i.frame_lane),
      .word_par_ena, .odd_sense, .corrupt, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
      .alarm_pin, .dac_out_on);

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // running word stream; a block start spans two words so one lands on a rising slot
   always @(posedge mclk) begin
      if (word_ready && word_valid) begin
         #2;
         word_cnt = word_cnt + 1;
         word_data = word_data + 16'h1357;
         block_start = (word_cnt % 16) < 2;
      end
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      idle(1);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      idle(1);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [REG_ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      idle(1);
      reg_addr = a;
      idle(2);
      v = reg_rdata;
   endtask

   // poll one status bit until it reads the wanted level
   task automatic wait_bit(input int b, input logic e);
      for (int i = 0; i < 300; i++) begin
         rd(ADDR_STATUS, rd_val);
         if (rd_val[b] === e) break;
      end
      check(16'(rd_val[b]), 16'(e));
      if (rd_val[b] !== e) test_done();
   endtask

   task automatic t_reset();
      rd(ADDR_SETUP, rd_val);
      check(rd_val, SETUP_RESET);
      rd(ADDR_SHUTOFF, rd_val);
      check(rd_val, SHUTOFF_RESET);
      rd(ADDR_MASK, rd_val);
      check(rd_val, MASK_RESET);
      rd(3'h3, rd_val);
      check(rd_val, 16'h0000);
      idle(150);
      wr(ADDR_STATUS, 16'h0000);
      idle(50);
      rd(ADDR_STATUS, rd_val);
      check(rd_val, STATUS_RESET);
      check(16'(alarm_pin), 16'h0000);
      check(16'(dac_out_on), 16'h0001);
      $display("reset values done");
   endtask

   task automatic t_word();
      for (int s = 1; s >= 0; s--) begin
         word_par_ena = 1'b1;
         odd_sense = s[0];
         wr(ADDR_SETUP, {14'h0000, s[0], 1'b1});
         idle(100);
         wr(ADDR_STATUS, 16'h0000);
         idle(200);
         rd(ADDR_STATUS, rd_val);
         check(rd_val & 16'h1C00, 16'h0000);
      end
      corrupt = 1'b1;
      wait_bit(AL_RPARITY, 1'b1);
      wait_bit(AL_FPARITY, 1'b1);
      corrupt = 1'b0;
      idle(50);
      wr(ADDR_STATUS, 16'h0000);
      wait_bit(AL_RPARITY, 1'b0);
      $display("word parity done");
   endtask

   task automatic t_block();
      word_par_ena = 1'b0;
      block_par_ena = 1'b1;
      wr(ADDR_SETUP, 16'h0004);
      idle(200);
      wr(ADDR_STATUS, 16'h0000);
      idle(300);
      rd(ADDR_STATUS, rd_val);
      check(rd_val & 16'h1C00, 16'h0000);
      corrupt = 1'b1;
      wait_bit(AL_FRAME_PAR, 1'b1);
      rd(ADDR_STATUS, rd_val);
      check(16'(rd_val[AL_RPARITY]), 16'h0000);
      corrupt = 1'b0;
      idle(100);
      wr(ADDR_STATUS, 16'h0000);
      idle(300);
      wait_bit(AL_FRAME_PAR, 1'b0);
      $display("block parity done");
   endtask

   task automatic t_alarm();
      wr(ADDR_MASK, 16'hFDFF);
      pll_locked = 1'b0;
      wait_bit(AL_PLL, 1'b1);
      idle(3);
      check(16'(alarm_pin), 16'h0001);
      wr(ADDR_STATUS, 16'h0000);
      idle(20);
      wait_bit(AL_PLL, 1'b1);
      pattern_mismatch = 1'b1;
      wait_bit(AL_IOTEST, 1'b1);
      pll_locked = 1'b1;
      pattern_mismatch = 1'b0;
      idle(20);
      wr(ADDR_STATUS, 16'h0000);
      wait_bit(AL_PLL, 1'b0);
      idle(3);
      check(16'(alarm_pin), 16'h0000);
      wr(ADDR_MASK, 16'hFFFF);
      $display("alarm pin done");
   endtask

   task automatic t_fifo();
      logic [PTR_W-1:0] wp[4] = '{8'h01, 8'h01, 8'h01, 8'h00};
      logic [PTR_W-1:0] rp[4] = '{8'h01, 8'h02, 8'h04, 8'h10};
      int               bits[4] = '{AL_COLLISION, AL_ONE_APART, AL_TWO_APART, AL_ZERO_CHK};
      wr(ADDR_SHUTOFF, 16'h0006);
      for (int i = 0; i < 4; i++) begin
         fifo_wr_ptr = wp[i];
         fifo_rd_ptr = rp[i];
         idle(10);
         wr(ADDR_STATUS, 16'h0000);
         wait_bit(bits[i], 1'b1);
         if (i < 3) wait_bit(AL_FIFO, 1'b1);
         idle(3);
         if (i == 0) check(16'(dac_out_on), 16'h0000);
      end
      fifo_wr_ptr = 8'h01;
      fifo_rd_ptr = 8'h10;
      idle(10);
      wr(ADDR_STATUS, 16'h0000);
      wait_bit(AL_FIFO, 1'b0);
      $display("fifo alarms done");
   endtask

   initial begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 16'h0000;
      word_data = 16'h0000;
      word_valid = 1'b1;
      block_start = 1'b0;
      word_par_ena = 1'b0;
      odd_sense = 1'b0;
      block_par_ena = 1'b0;
      corrupt = 1'b0;
      fifo_wr_ptr = 8'h01;
      fifo_rd_ptr = 8'h10;
      pll_locked = 1'b1;
      pattern_mismatch = 1'b0;
      tx_enable_pin = 1'b1;
      n_errors = 0;
      cmp_count = 0;
      word_cnt = 0;
      idle(12);
      resetn = 1'b1;
      t_reset();
      t_word();
      t_block();
      t_alarm();
      t_fifo();
      test_done();
   end
endmodule
`default_nettype wire

// File: tb/parity_link_assertions.sv
// Purpose: lane timing, reset and readback checks beside the link interface
// Assumes: source and monitor both run on mclk; lanes launch from mclk flops
// Notes:   instantiated in the bench top, no bind
`timescale 1ns/1ps
`default_nettype none
module parity_link_assertions (
   // clock and reset
   input wire logic                                    mclk,
   input wire logic                                    resetn,
   // link lanes
   input wire logic                                    dataclk,
   input wire logic [parity_alarm_pkg::DATA_W-1:0]     data,
   input wire logic                                    check_bit_lane,
   input wire logic                                    frame_lane,
   // source settings
   input wire logic                                    word_par_ena,
   input wire logic                                    odd_sense,
   input wire logic                                    corrupt,
   // register port and outputs
   input wire logic                                    reg_wr,
   input wire logic [parity_alarm_pkg::REG_ADDR_W-1:0] reg_addr,
   input wire logic [parity_alarm_pkg::DATA_W-1:0]     reg_wdata,
   input wire logic [parity_alarm_pkg::DATA_W-1:0]     reg_rdata,
   input wire logic                                    alarm_pin,
   input wire logic                                    dac_out_on
);
   import parity_alarm_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   clk_high_a: assert property ($rose(dataclk) |=> dataclk ##1 !dataclk)
      else $error("data clock high phase is not two cycles");
   clk_low_a: assert property ($fell(dataclk) |=> !dataclk ##1 dataclk)
      else $error("data clock low phase is not two cycles");
   lanes_reset_a: assert property (disable iff (1'b0)
      !resetn && $past(!resetn) |-> !dataclk && data == 16'h0000 && !check_bit_lane && !frame_lane)
      else $error("lanes not idle in reset");
   outs_reset_a: assert property (disable iff (1'b0)
      !resetn && $past(!resetn) |-> !alarm_pin && !dac_out_on && reg_rdata == 16'h0000)
      else $error("monitor outputs not cleared in reset");
   lane_settle_a: assert property (
      ($changed(data) || $changed(check_bit_lane) || $changed(frame_lane)) |-> $stable(dataclk))
      else $error("lane moved together with the data clock");
   word_parity_a: assert property (
      $changed(dataclk) && word_par_ena && $past(word_par_ena, 4) && !corrupt
      && !$past(corrupt, 4) && odd_sense == $past(odd_sense, 4)
      |-> (^{data, check_bit_lane}) == odd_sense)
      else $error("check bit does not give the chosen sense");
   unmapped_read_a: assert property (
      (reg_addr == 3'h0 || reg_addr == 3'h3 || reg_addr == 3'h4 || reg_addr == 3'h6)
      |=> reg_rdata == 16'h0000)
      else $error("unmapped address read nonzero");
   masked_pin_a: assert property (
      reg_wr && reg_addr == ADDR_MASK && reg_wdata == 16'hFFFF |-> ##2 !alarm_pin)
      else $error("alarm pin high with every alarm masked");
endmodule
`default_nettype wire
